/* File: core/ppc_pkg.sv */
// Package for the eight-loop periodic feedback controller
package ppc_pkg;
    localparam int NLOOP = 8;
    localparam int NFIELD = 14;
    localparam int AW = 8;
    // Field indices inside a loop's register group (addr[3:0])
    localparam logic [3:0] F_CTRL = 4'h0;
    localparam logic [3:0] F_SEL = 4'h1;
    localparam logic [3:0] F_SETPT = 4'h2;
    localparam logic [3:0] F_DZONE = 4'h3;
    localparam logic [3:0] F_PGAIN = 4'h4;
    localparam logic [3:0] F_IGAIN = 4'h5;
    localparam logic [3:0] F_DGAIN = 4'h6;
    localparam logic [3:0] F_MIN = 4'h7;
    localparam logic [3:0] F_MAX = 4'h8;
    localparam logic [3:0] F_PERIOD = 4'h9;
    localparam logic [3:0] F_DT = 4'ha;
    localparam logic [3:0] F_INVDT = 4'hb;
    localparam logic [3:0] F_SCLO = 4'hc;
    localparam logic [3:0] F_SCHI = 4'hd;
    localparam logic [3:0] F_OUT = 4'he;
    localparam logic [3:0] F_INTEG = 4'hf;
    // Global group at addr[7:4] == G_GROUP
    localparam logic [3:0] G_GROUP = 4'h8;
    localparam logic [3:0] G_OPT = 4'h0;
    localparam logic [3:0] G_STAT = 4'h1;
    // Bit positions
    localparam int B_EN = 0;
    localparam int B_LIM = 1;
    localparam int B_GSRC = 2;
    localparam int S_IN = 0;
    localparam int S_OUT = 8;
    localparam int S_KP = 16;
    localparam int S_KI = 20;
    localparam int S_KD = 24;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] F_ZERO = 32'h0000_0000;
    localparam logic [31:0] F_INF = 32'h7f80_0000;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } ppc_bus_s;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_SCAN = 8'h02,
        ST_ERR = 8'h04,
        ST_PT = 8'h08,
        ST_I1 = 8'h10,
        ST_I2 = 8'h20,
        ST_D1 = 8'h40,
        ST_D2 = 8'h80
    } ppc_state_e;
endpackage

/* File: core/ppc_core.sv */
// Eight periodic feedback control loops with a plain register port
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module ppc_core #(
    parameter int NL = ppc_pkg::NLOOP
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire ppc_pkg::ppc_bus_s bus_i,
    output logic [31:0] rdata_o,
    input wire logic tick_i,
    input wire logic switch_en_i,
    input wire logic [NL-1:0][31:0] fb_i,
    output logic [NL-1:0][31:0] out_o
);
    import ppc_pkg::*;

    typedef struct packed {
        logic [NL-1:0][NFIELD-1:0][31:0] cfg;
        logic [NL-1:0][31:0] cnt;
        logic [NL-1:0] due;
        logic [NL-1:0][31:0] integ;
        logic [NL-1:0][31:0] prev;
        logic [NL-1:0] wind;
        logic [NL-1:0][31:0] out;
        logic [2:0] idx;
        ppc_state_e st;
        logic [31:0] err;
        logic [31:0] acc;
        logic [31:0] tmp;
        logic [31:0] rdata;
        logic force_opt;
        logic sw_s1;
        logic sw_s2;
    } ppc_reg_s;

    ppc_reg_s r_q, r_d;

    // Float multiply, truncating, denormals flushed to zero
    function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
        logic [47:0] m;
        logic signed [9:0] e;
        logic [22:0] mm;
        m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        e = $signed({2'b00, a[30:23]}) + $signed({2'b00, b[30:23]}) - 10'sd127;
        mm = m[47] ? m[46:24] : m[45:23];
        if (m[47]) begin
            e = e + 10'sd1;
        end
        if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e <= 10'sd0) begin
            fmul = F_ZERO;
        end else if (e >= 10'sd255) begin
            fmul = {a[31] ^ b[31], F_INF[30:0]};
        end else begin
            fmul = {a[31] ^ b[31], e[7:0], mm};
        end
    endfunction

    // Float add, truncating, denormals flushed to zero
    function automatic logic [31:0] fadd(input logic [31:0] x, input logic [31:0] y);
        logic [31:0] a, b;
        logic [25:0] ma, mb, s;
        logic [7:0] d;
        logic [8:0] e;
        logic done;
        a = (x[30:0] < y[30:0]) ? y : x;
        b = (x[30:0] < y[30:0]) ? x : y;
        ma = (a[30:23] == 8'h00) ? 26'h0 : {2'b01, a[22:0], 1'b0};
        mb = (b[30:23] == 8'h00) ? 26'h0 : {2'b01, b[22:0], 1'b0};
        d = a[30:23] - b[30:23];
        mb = (d > 8'd25) ? 26'h0 : (mb >> d);
        s = (a[31] == b[31]) ? ma + mb : ma - mb;
        e = {1'b0, a[30:23]};
        done = 1'b0;
        if (s[25]) begin
            s = s >> 1;
            e = e + 9'd1;
        end
        for (int k = 0; k < 25; k++) begin
            if (!done && !s[24] && e > 9'd1) begin
                s = s << 1;
                e = e - 9'd1;
            end else begin
                done = 1'b1;
            end
        end
        if (s == 26'h0 || !s[24]) begin
            fadd = F_ZERO;
        end else if (e >= 9'd255) begin
            fadd = {a[31], F_INF[30:0]};
        end else begin
            fadd = {a[31], e[7:0], s[23:1]};
        end
    endfunction

    // Float compare a < b, treating both zeros as equal
    function automatic logic flt(input logic [31:0] a, input logic [31:0] b);
        if (a[31] != b[31]) begin
            flt = a[31] && (a[30:0] != 31'h0 || b[30:0] != 31'h0);
        end else if (!a[31]) begin
            flt = a[30:0] < b[30:0];
        end else begin
            flt = a[30:0] > b[30:0];
        end
    endfunction

    // Working values of the loop that the sequencer is serving
    logic run_ok;
    logic [NFIELD-1:0][31:0] c;
    logic [2:0] osel;
    logic [31:0] kp, ki, kd, lo, hi, y, di, ni;
    logic lim;

    assign run_ok = r_q.sw_s2;
    assign c = r_q.cfg[r_q.idx];
    assign osel = c[F_SEL][S_OUT +: 3];
    assign lim = c[F_CTRL][B_LIM];
    // One selector picks the source of all three gains together
    assign kp = c[F_CTRL][B_GSRC] ? fb_i[c[F_SEL][S_KP +: 3]] : c[F_PGAIN];
    assign ki = c[F_CTRL][B_GSRC] ? fb_i[c[F_SEL][S_KI +: 3]] : c[F_IGAIN];
    assign kd = c[F_CTRL][B_GSRC] ? fb_i[c[F_SEL][S_KD +: 3]] : c[F_DGAIN];
    // Bounds: programmed limits or the output point's scale range
    assign lo = lim ? c[F_MIN] : r_q.cfg[osel][F_SCLO];
    assign hi = lim ? c[F_MAX] : r_q.cfg[osel][F_SCHI];
    // Integral step, new integral sum and the final three-term sum
    assign di = fmul(r_q.err, c[F_DT]);
    assign ni = fadd(r_q.integ[r_q.idx], di);
    assign y = fadd(r_q.acc, fmul(r_q.tmp, kd));

    // Next-state logic: register port, period counters, loop sequencer
    always_comb begin
        r_d = r_q;
        r_d.sw_s1 = switch_en_i;
        r_d.sw_s2 = r_q.sw_s1;
        r_d.rdata = RST_WORD;
        if (bus_i.we) begin
            if (bus_i.addr[7:4] == G_GROUP && bus_i.addr[3:0] == G_OPT) begin
                r_d.force_opt = bus_i.wdata[0];
            end else if (bus_i.addr[7] == 1'b0 && bus_i.addr[3:0] < F_OUT) begin
                r_d.cfg[bus_i.addr[6:4]][bus_i.addr[3:0]] = bus_i.wdata;
            end
        end
        if (bus_i.re) begin
            if (bus_i.addr[7:4] == G_GROUP && bus_i.addr[3:0] == G_OPT) begin
                r_d.rdata = {31'h0, r_q.force_opt};
            end else if (bus_i.addr[7:4] == G_GROUP && bus_i.addr[3:0] == G_STAT) begin
                r_d.rdata = {24'h0, r_q.st == ST_IDLE, r_q.sw_s2, 3'h0, r_q.idx};
            end else if (bus_i.addr[7] == 1'b0 && bus_i.addr[3:0] == F_OUT) begin
                r_d.rdata = r_q.out[bus_i.addr[6:4]];
            end else if (bus_i.addr[7] == 1'b0 && bus_i.addr[3:0] == F_INTEG) begin
                r_d.rdata = r_q.integ[bus_i.addr[6:4]];
            end else if (bus_i.addr[7] == 1'b0) begin
                r_d.rdata = r_q.cfg[bus_i.addr[6:4]][bus_i.addr[3:0]];
            end
        end
        // Sequencer; clearing a due flag comes before a new tick can set it
        case (r_q.st)
            ST_IDLE: begin
                r_d.idx = 3'h0;
                if (|r_q.due) begin
                    r_d.st = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (r_q.due[r_q.idx] && run_ok) begin
                    r_d.st = ST_ERR;
                end else begin
                    r_d.due[r_q.idx] = 1'b0;
                    r_d.idx = r_q.idx + 3'h1;
                    r_d.st = (r_q.idx == 3'(NL - 1)) ? ST_IDLE : ST_SCAN;
                end
            end
            ST_ERR: begin
                // Feedback minus setpoint: the setpoint's sign bit is flipped
                r_d.err = fadd(fb_i[c[F_SEL][S_IN +: 3]], {~c[F_SETPT][31], c[F_SETPT][30:0]});
                r_d.st = ST_PT;
            end
            ST_PT: begin
                // Inside the dead zone the loop is served and its error kept as the previous one, but output and integral hold
                if (!flt(c[F_DZONE], {1'b0, r_q.err[30:0]})) begin
                    r_d.due[r_q.idx] = 1'b0;
                    r_d.prev[r_q.idx] = r_q.err;
                    r_d.idx = r_q.idx + 3'h1;
                    r_d.st = (r_q.idx == 3'(NL - 1)) ? ST_IDLE : ST_SCAN;
                end else begin
                    r_d.acc = fmul(r_q.err, kp);
                    r_d.st = ST_I1;
                end
            end
            ST_I1: begin
                // A wound-up loop keeps its integral sum for this run
                if (!r_q.wind[r_q.idx]) begin
                    r_d.integ[r_q.idx] = ni;
                end
                r_d.st = ST_I2;
            end
            ST_I2: begin
                r_d.acc = fadd(r_q.acc, fmul(r_q.integ[r_q.idx], ki));
                r_d.st = ST_D1;
            end
            ST_D1: begin
                // Rate of change of the error, scaled by 1/dt
                r_d.tmp = fmul(fadd(r_q.err, {~r_q.prev[r_q.idx][31],
                    r_q.prev[r_q.idx][30:0]}), c[F_INVDT]);
                r_d.st = ST_D2;
            end
            ST_D2: begin
                // Clamp, mark windup, write the output point
                r_d.out[osel] = y;
                if (lim && flt(y, lo)) begin
                    r_d.out[osel] = lo;
                end else if (lim && flt(hi, y)) begin
                    r_d.out[osel] = hi;
                end
                r_d.wind[r_q.idx] = !flt(lo, y) || !flt(y, hi);
                r_d.prev[r_q.idx] = r_q.err;
                r_d.due[r_q.idx] = 1'b0;
                r_d.idx = r_q.idx + 3'h1;
                r_d.st = (r_q.idx == 3'(NL - 1)) ? ST_IDLE : ST_SCAN;
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase
        // Per-loop reload counters in execution ticks
        // Enable is taken from the next value, so a loop switched off by software
        // never stands due while its enable bit already reads clear
        for (int i = 0; i < NL; i++) begin
            if (!r_d.cfg[i][F_CTRL][B_EN] || !run_ok) begin
                r_d.cnt[i] = RST_WORD;
                r_d.due[i] = 1'b0;
            end else if (tick_i && r_q.cnt[i] == RST_WORD) begin
                r_d.due[i] = 1'b1;
                r_d.cnt[i] = (r_q.cfg[i][F_PERIOD] == RST_WORD) ? RST_WORD
                    : r_q.cfg[i][F_PERIOD] - 32'h1;
            end else if (tick_i) begin
                r_d.cnt[i] = r_q.cnt[i] - 32'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    assign rdata_o = r_q.rdata;
    // Outputs forced off while the switch is disabled, when so configured
    assign out_o = (r_q.force_opt && !r_q.sw_s2) ? '0 : r_q.out;

    // Checks on switch gating, loop order, clamping, windup and dead zone
    chk_disabled_idle: assert property (@(posedge clock_i) disable iff (rst_i)
        !r_q.sw_s2 |=> r_q.due == '0)
        else $error("loop due while switch disabled");
    chk_force_off: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_q.force_opt && !r_q.sw_s2) |-> out_o == '0)
        else $error("outputs not forced off");
    chk_enable_gate: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_q.st == ST_SCAN && r_q.due[r_q.idx]) |-> r_q.cfg[r_q.idx][F_CTRL][B_EN])
        else $error("disabled loop is due");
    chk_ascending: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_q.st == ST_D2 && r_q.idx != 3'(NL - 1)) |=> r_q.idx == $past(r_q.idx) + 3'h1)
        else $error("loop order broken");
    chk_step_order: assert property (@(posedge clock_i) disable iff (rst_i)
        r_q.st == ST_I1 |=> r_q.st == ST_I2 ##1 r_q.st == ST_D1 ##1 r_q.st == ST_D2)
        else $error("term sequence broken");
    chk_clamp_lo: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_q.st == ST_D2 && lim && !(rst_i)) |=> !flt(r_q.out[$past(osel)], $past(lo)))
        else $error("output below minimum");
    chk_clamp_hi: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_q.st == ST_D2 && lim) |=> !flt($past(hi), r_q.out[$past(osel)]))
        else $error("output above maximum");
    chk_windup_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_q.st == ST_I1 && r_q.wind[r_q.idx]) |=> $stable(r_q.integ))
        else $error("integral moved while wound up");
    chk_deadzone: assert property (@(posedge clock_i) disable iff (rst_i)
        (r_q.st == ST_PT && !flt(c[F_DZONE], {1'b0, r_q.err[30:0]})) |=> $stable(r_q.out))
        else $error("output moved inside dead zone");
endmodule // ppc_core

/* File: testbench/ppc_plant.sv */
// Process side model: the feedback points that the loops read
`timescale 1ns/100ps
module ppc_plant (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic [2:0] idx_i,
    input wire logic [31:0] val_i,
    output logic [ppc_pkg::NLOOP-1:0][31:0] fb_o
);
    import ppc_pkg::*;
    // Each point holds a float in the setpoint's units until the bench moves it
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            fb_o <= '0;
        end else if (set_i) begin
            fb_o[idx_i] <= val_i;
        end
    end
endmodule // ppc_plant

/* File: testbench/tb_ppc_core.sv */
// Self-checking testbench for the eight-loop feedback controller
`timescale 1ns/100ps
module tb_ppc_core;
    import ppc_pkg::*;
    localparam logic [31:0] ONE = 32'h3f80_0000;
    localparam logic [31:0] TWO = 32'h4000_0000;
    localparam logic [31:0] HALF = 32'h3f00_0000;
    localparam logic [31:0] QTR = 32'h3e80_0000;
    localparam logic [31:0] THREE = 32'h4040_0000;
    localparam logic [31:0] FOUR = 32'h4080_0000;
    localparam logic [31:0] NEG1 = 32'hbf80_0000;
    localparam logic [31:0] H100 = 32'h42c8_0000;
    localparam logic [31:0] N100 = 32'hc2c8_0000;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    ppc_bus_s bus = '0;
    logic [31:0] rdata;
    logic tick = 1'b0;
    logic switch_en = 1'b1;
    logic [NLOOP-1:0][31:0] fb;
    logic [NLOOP-1:0][31:0] out;
    logic fb_we = 1'b0;
    logic [2:0] fb_idx = 3'h0;
    logic [31:0] fb_val = 32'h0;
    logic [31:0] rv;
    int errors = 0;
    int tests_run = 0;

    // Free-running 100 MHz clock
    always #5 clock_i = ~clock_i;

    ppc_core #(.NL(NLOOP)) i_ppc_core (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus),
        .rdata_o(rdata), .tick_i(tick), .switch_en_i(switch_en), .fb_i(fb), .out_o(out));
    ppc_plant i_ppc_plant (.clock_i(clock_i), .rst_i(rst_i), .set_i(fb_we), .idx_i(fb_idx),
        .val_i(fb_val), .fb_o(fb));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clock_i);
        bus.we <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clock_i);
        bus.re <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic setfb(input logic [2:0] i, input logic [31:0] v);
        @(posedge clock_i);
        fb_we <= 1'b1;
        fb_idx <= i;
        fb_val <= v;
        @(posedge clock_i);
        fb_we <= 1'b0;
    endtask

    // Parameter set of one loop but the control word, setpoint zero, dt and 1/dt one
    task automatic cfg(input logic [3:0] n, input logic [31:0] sel, kp, ki, kd, dz, lo, hi);
        wr({n, F_SEL}, sel);
        wr({n, F_SETPT}, F_ZERO);
        wr({n, F_DZONE}, dz);
        wr({n, F_PGAIN}, kp);
        wr({n, F_IGAIN}, ki);
        wr({n, F_DGAIN}, kd);
        wr({n, F_MIN}, lo);
        wr({n, F_MAX}, hi);
        wr({n, F_PERIOD}, 32'h1);
        wr({n, F_DT}, ONE);
        wr({n, F_INVDT}, ONE);
        wr({n, F_SCLO}, lo);
        wr({n, F_SCHI}, hi);
    endtask

    // One tick, then room for a full pass over all loops
    task automatic pulse();
        @(posedge clock_i);
        tick <= 1'b1;
        @(posedge clock_i);
        tick <= 1'b0;
        repeat (70) @(posedge clock_i);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(8'h0e, rv);
        chk(rv, F_ZERO);
        rd(8'h90, rv);
        chk(rv, RST_WORD);
        setfb(3'h0, TWO);
        setfb(3'h4, TWO);
        setfb(3'h6, TWO);
        setfb(3'h7, HALF);
        cfg(4'h0, 32'h0, ONE, HALF, QTR, F_ZERO, N100, H100);
        cfg(4'h1, 32'h100, ONE, HALF, QTR, THREE, N100, H100);
        cfg(4'h2, 32'h200, ONE, HALF, F_ZERO, F_ZERO, NEG1, ONE);
        cfg(4'h3, 32'h300, ONE, HALF, F_ZERO, F_ZERO, NEG1, ONE);
        cfg(4'h4, 32'h404, ONE, F_ZERO, F_ZERO, F_ZERO, N100, H100);
        cfg(4'h5, 32'h506, ONE, F_ZERO, F_ZERO, F_ZERO, N100, H100);
        cfg(4'h6, 32'h506, HALF, F_ZERO, F_ZERO, F_ZERO, N100, H100);
        cfg(4'h7, 32'h0337_0706, F_ZERO, F_ZERO, F_ZERO, F_ZERO, N100, H100);
        wr(8'h49, 32'h2);
        wr(8'h4a, HALF);
        for (int n = 0; n < NLOOP; n++) begin
            wr({n[3:0], F_CTRL}, (n == 2) ? 32'h3 : ((n == 7) ? 32'h5 : 32'h1));
        end
        pulse();
        chk(out[0], 32'h4060_0000);
        chk(out[1], F_ZERO);
        chk(out[2], ONE);
        chk(out[3], THREE);
        chk(out[4], TWO);
        chk(out[5], ONE);
        chk(out[6], F_ZERO);
        chk(out[7], ONE);
        rd(8'h0f, rv);
        chk(rv, TWO);
        setfb(3'h4, ONE);
        pulse();
        chk(out[0], FOUR);
        rd(8'h2f, rv);
        chk(rv, TWO);
        rd(8'h3f, rv);
        chk(rv, TWO);
        chk(out[3], THREE);
        chk(out[4], TWO);
        wr(8'h00, 32'h0);
        pulse();
        chk(out[4], ONE);
        chk(out[0], FOUR);
        rd(8'h0e, rv);
        chk(rv, FOUR);
        rd(8'h4f, rv);
        chk(rv, 32'h3fc0_0000);
        switch_en <= 1'b0;
        setfb(3'h6, ONE);
        pulse();
        chk(out[7], ONE);
        rd(8'h81, rv);
        chk({24'h0, rv[7:6], 6'h0}, 32'h80);
        wr(8'h80, 32'h1);
        repeat (3) @(posedge clock_i);
        chk(out[0], F_ZERO);
        chk(out[7], F_ZERO);
        switch_en <= 1'b1;
        repeat (4) @(posedge clock_i);
        pulse();
        chk(out[7], HALF);
        chk(out[5], HALF);
        conclude();
    end

    // Watchdog against a hung sequencer or bus
    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        conclude();
    end
endmodule // tb_ppc_core
